//--- tb_uhp_pipe_irq.sv
// Purpose: Self-checking bench of the pipe flag block.
// Assumes: Eight pipes, registers in the low byte lane.
// Notes:   Reference state is kept in fl, en, tg, bk.
module tb_uhp_pipe_irq;
    timeunit 1ns;
    timeprecision 1ps;
    logic                 clock, rst, usbReset, irq;
    logic [1:0]           lag;
    uhp_pkg::uhp_wb_req_s wbReq;
    uhp_pkg::uhp_wb_rsp_s wbRsp;
    uhp_pkg::uhp_evt_s    cmd, evt;
    logic [7:0]           pipeToggle, pipeBank, pipeFreeze;
    logic [7:0]           fl[8], en[8];
    logic [7:0]           tg, bk, dbl, rd, d;
    int                   error_cnt = 0, n_tests = 0, tmo = 0;
    uhp_pipe_irq dut (.clock(clock), .rst(rst), .wbReq(wbReq), .wbRsp(wbRsp), .evt(evt),
        .usbReset(usbReset), .pipeToggle(pipeToggle), .pipeBank(pipeBank),
        .pipeFreeze(pipeFreeze), .irq(irq));
    uhp_usb_dev dev (.clock(clock), .cmd(cmd), .lag(lag), .evt(evt));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock) begin
        tmo++;
        if (tmo > 5000) begin
            error_cnt++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    function automatic logic [9:0] ix(input logic [9:0] b, input int p);
        return b + uhp_pkg::PIPE_STRIDE * 10'(p);
    endfunction
    function automatic logic [7:0] irq_exp();
        logic r;
        r = 1'b0;
        for (int p = 0; p < 8; p++) r |= |(fl[p] & en[p]);
        return {7'h0, r};
    endfunction
    task automatic wb(input logic w, input logic [9:0] a, input logic [7:0] v);
        int n;
        n = 0;
        @(posedge clock);
        wbReq <= '{1'b1, 1'b1, w, 4'h1, {a, 2'b00}, {24'h0, v}};
        do begin
            @(posedge clock);
            n++;
        end while (wbRsp.ack !== 1'b1 && n < 50);
        if (n >= 50) begin
            error_cnt++;
            end_of_test();
        end
        rd = wbRsp.dat[7:0];
        wbReq <= '0;
    endtask
    task automatic rchk(input string nm, input logic [9:0] a, input logic [7:0] e);
        wb(1'b0, a, 8'h00);
        chk(nm, e, rd);
    endtask
    task automatic ev(input int p, input uhp_pkg::uhp_evt_e k, input uhp_pkg::uhp_tok_e t);
        logic s;
        s = t == uhp_pkg::UHP_TOK_SETUP;
        case (k)
            uhp_pkg::UHP_EV_STALL: fl[p][5] = 1'b1;
            uhp_pkg::UHP_EV_PIPE_ERROR_FLAG: fl[p][3] = 1'b1;
            uhp_pkg::UHP_EV_TRANSFER_FAIL_FLAG: fl[p][2] = 1'b1;
            default: begin
                tg[p] = s ? 1'b1 : ~tg[p];
                if (s) fl[p][4] = 1'b1;
                else fl[p][dbl[p] & bk[p]] = 1'b1;
                if (!s && dbl[p]) bk[p] = ~bk[p];
            end
        endcase
        @(posedge clock);
        cmd <= '{1'b1, 3'(p), k, t};
        lag <= 2'($urandom_range(3));
        @(posedge clock);
        cmd.valid <= 1'b0;
        repeat (6) @(posedge clock);
        chk("toggle", tg, pipeToggle);
        chk("bank", bk, pipeBank);
        chk("irq", irq_exp(), {7'h0, irq});
        if (k == uhp_pkg::UHP_EV_STALL) chk("freeze", 8'h01, {7'h0, pipeFreeze[p]});
    endtask
    initial begin
        void'($urandom(37169));
        rst = 1'b1;
        usbReset = 1'b0;
        wbReq = '0;
        cmd = '0;
        lag = 2'h0;
        tg = 8'h00;
        bk = 8'h00;
        for (int p = 0; p < 8; p++) begin
            fl[p] = 8'h00;
            en[p] = 8'h00;
        end
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        for (int p = 0; p < 8; p++) begin
            rchk("flags", ix(uhp_pkg::IDX_FLAGS, p), 8'h00);
            rchk("ienset", ix(uhp_pkg::IDX_IEN_SET, p), 8'h00);
        end
        rchk("unmapped", 10'h3ff, 8'h00);
        dbl = 8'($urandom);
        wb(1'b1, uhp_pkg::IDX_PIPE_EN, 8'hff);
        wb(1'b1, uhp_pkg::IDX_DBL_BANK, dbl);
        for (int p = 0; p < 8; p++) begin
            d = 8'($urandom) & 8'h3f;
            en[p] = d;
            wb(1'b1, ix(uhp_pkg::IDX_IEN_SET, p), d);
            d = 8'($urandom) & 8'h3f;
            en[p] &= ~d;
            wb(1'b1, ix(uhp_pkg::IDX_IEN_CLR, p), d);
        end
        ev(0, uhp_pkg::UHP_EV_DONE, uhp_pkg::UHP_TOK_SETUP);
        ev(7, uhp_pkg::UHP_EV_STALL, uhp_pkg::UHP_TOK_OUT);
        repeat (40) ev($urandom_range(7), uhp_pkg::uhp_evt_e'($urandom_range(3)),
            uhp_pkg::uhp_tok_e'($urandom_range(2)));
        for (int p = 0; p < 8; p++) begin
            rchk("flags", ix(uhp_pkg::IDX_FLAGS, p), fl[p]);
            d = 8'($urandom) & 8'h3f;
            fl[p] &= ~d;
            wb(1'b1, ix(uhp_pkg::IDX_FLAGS, p), d);
            rchk("w1c", ix(uhp_pkg::IDX_FLAGS, p), fl[p]);
            rchk("ienset", ix(uhp_pkg::IDX_IEN_SET, p), en[p]);
            rchk("ienclr", ix(uhp_pkg::IDX_IEN_CLR, p), en[p]);
        end
        chk("irq", irq_exp(), {7'h0, irq});
        d = 8'h00;
        for (int p = 0; p < 8; p++) d[p] = |(fl[p] & en[p]);
        rchk("pending", uhp_pkg::IDX_IRQ_PEND, d);
        wb(1'b1, ix(uhp_pkg::IDX_STAT_CLR, 3), 8'h01);
        wb(1'b1, ix(uhp_pkg::IDX_STAT_SET, 3), 8'h01);
        tg[3] = 1'b1;
        @(posedge clock);
        chk("toggle", tg, pipeToggle);
        wb(1'b1, ix(uhp_pkg::IDX_STAT_CLR, 3), 8'h01);
        tg[3] = 1'b0;
        @(posedge clock);
        chk("toggle", tg, pipeToggle);
        wb(1'b1, uhp_pkg::IDX_PIPE_EN, 8'hfb);
        en[2] = 8'h00;
        rchk("ienset", ix(uhp_pkg::IDX_IEN_SET, 2), 8'h00);
        chk("irq", irq_exp(), {7'h0, irq});
        wb(1'b1, ix(uhp_pkg::IDX_IEN_SET, 0), 8'h3f);
        en[0] = 8'h3f;
        usbReset <= 1'b1;
        @(posedge clock);
        usbReset <= 1'b0;
        repeat (3) @(posedge clock);
        chk("toggle", 8'h00, pipeToggle);
        chk("bank", 8'h00, pipeBank);
        chk("irq", 8'h00, {7'h0, irq});
        rchk("flags", ix(uhp_pkg::IDX_FLAGS, 7), 8'h00);
        rchk("ienset", ix(uhp_pkg::IDX_IEN_SET, 0), 8'h00);
        end_of_test();
    end
endmodule

//--- uhp_pipe_irq.sv
// Purpose: Per-pipe toggle, freeze, bank, interrupt flags and enables of a USB host.
// Assumes: Events come from the transaction engine on the same clock.
// Notes:   Registers sit in the low byte lane; writes act on the acknowledged edge.
module uhp_pipe_irq (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst,
    // Wishbone slave
    input  wire uhp_pkg::uhp_wb_req_s   wbReq,
    output uhp_pkg::uhp_wb_rsp_s        wbRsp,
    // Transaction engine side
    input  wire uhp_pkg::uhp_evt_s      evt,
    input  wire logic                   usbReset,
    output logic [7:0]                  pipeToggle,
    output logic [7:0]                  pipeBank,
    output logic [7:0]                  pipeFreeze,
    // Processor interrupt
    output logic                        irq
);

    localparam int NP = uhp_pkg::PIPE_COUNT;

    logic [5:0]  flags_q [NP];
    logic [5:0]  ien_q   [NP];
    logic [7:0]  pen_q;
    logic [7:0]  dbl_q;
    logic [7:0]  bk0rdy_q;
    logic [7:0]  bk1rdy_q;
    logic        ack_q;
    logic [31:0] rdat_q;
    logic        irq_q;
    logic        irqAny;

    logic [9:0]  idx;
    logic [7:0]  wByte;
    logic        wrEn;
    logic [7:0]  stClrW;
    logic [7:0]  stSetW;
    logic [7:0]  flgW;
    logic [7:0]  ienClrW;
    logic [7:0]  ienSetW;
    logic        penW;
    logic        dblW;
    logic [7:0]  penRise;
    logic [7:0]  evHit;
    logic [7:0]  rdByte;

    // Index of a per-pipe register
    function automatic logic pipeHit(input logic [9:0] i, input logic [9:0] base, input int p);
        return i == (base + uhp_pkg::PIPE_STRIDE * 10'(p));
    endfunction

    // Flags raised by one engine event on a pipe
    function automatic logic [5:0] eventFlags(input uhp_pkg::uhp_evt_s e, input logic dbl,
                                              input logic bank);
        logic [5:0] f;
        f = 6'h00;
        case (e.kind)
            uhp_pkg::UHP_EV_STALL:  f[uhp_pkg::FB_STALL]  = 1'b1;
            uhp_pkg::UHP_EV_PIPE_ERROR_FLAG:   f[uhp_pkg::FB_PIPE_ERROR_FLAG]   = 1'b1;
            uhp_pkg::UHP_EV_TRANSFER_FAIL_FLAG: f[uhp_pkg::FB_TRANSFER_FAIL_FLAG] = 1'b1;
            default: begin
                if (e.token == uhp_pkg::UHP_TOK_SETUP) begin
                    f[uhp_pkg::FB_SETUP] = 1'b1;
                end else if (dbl && bank) begin
                    f[uhp_pkg::FB_DONE1] = 1'b1;
                end else begin
                    f[uhp_pkg::FB_DONE0] = 1'b1;
                end
            end
        endcase
        return f;
    endfunction

    assign idx   = wbReq.adr[11:2];
    assign wByte = wbReq.dat[7:0];
    // Write commits on the edge at which the master samples ack
    assign wrEn  = wbReq.cyc && wbReq.stb && wbReq.we && ack_q && wbReq.sel[0];

    // Write decode
    always_comb begin
        penW = 1'b0;
        dblW = 1'b0;
        if (wrEn && idx == uhp_pkg::IDX_PIPE_EN) begin
            penW = 1'b1;
        end else if (wrEn && idx == uhp_pkg::IDX_DBL_BANK) begin
            dblW = 1'b1;
        end
        for (int p = 0; p < NP; p++) begin
            stClrW[p]  = wrEn && pipeHit(idx, uhp_pkg::IDX_STAT_CLR, p);
            stSetW[p]  = wrEn && pipeHit(idx, uhp_pkg::IDX_STAT_SET, p);
            flgW[p]    = wrEn && pipeHit(idx, uhp_pkg::IDX_FLAGS, p);
            ienClrW[p] = wrEn && pipeHit(idx, uhp_pkg::IDX_IEN_CLR, p);
            ienSetW[p] = wrEn && pipeHit(idx, uhp_pkg::IDX_IEN_SET, p);
            evHit[p]   = evt.valid && (evt.pipe == 3'(p));
            penRise[p] = penW && wByte[p] && !pen_q[p];
        end
    end

    // Pipe enable and double-bank configuration
    always_ff @(posedge clock) begin
        if (rst) begin
            pen_q <= uhp_pkg::CTRL_RST;
            dbl_q <= uhp_pkg::CTRL_RST;
        end else begin
            if (penW) begin
                pen_q <= wByte;
            end
            if (dblW) begin
                dbl_q <= wByte;
            end
        end
    end

    // Data toggle: engine event wins over a software write in the same cycle
    always_ff @(posedge clock) begin
        for (int p = 0; p < NP; p++) begin
            if (rst || usbReset) begin
                pipeToggle[p] <= uhp_pkg::STAT_BIT_RST;
            end else if (evHit[p] && evt.kind == uhp_pkg::UHP_EV_DONE) begin
                if (evt.token == uhp_pkg::UHP_TOK_SETUP) begin
                    pipeToggle[p] <= 1'b1;
                end else begin
                    pipeToggle[p] <= ~pipeToggle[p];
                end
            end else if (stClrW[p] && wByte[uhp_pkg::SB_TOGGLE]) begin
                pipeToggle[p] <= 1'b0;
            end else if (stSetW[p] && wByte[uhp_pkg::SB_TOGGLE]) begin
                pipeToggle[p] <= 1'b1;
            end
        end
    end

    // Current bank flips after each data completion on a double-bank pipe
    always_ff @(posedge clock) begin
        for (int p = 0; p < NP; p++) begin
            if (rst || usbReset) begin
                pipeBank[p] <= uhp_pkg::STAT_BIT_RST;
            end else if (evHit[p] && evt.kind == uhp_pkg::UHP_EV_DONE
                         && evt.token != uhp_pkg::UHP_TOK_SETUP && dbl_q[p]) begin
                pipeBank[p] <= ~pipeBank[p];
            end else if (stClrW[p] && wByte[uhp_pkg::SB_BANK]) begin
                pipeBank[p] <= 1'b0;
            end else if (stSetW[p] && wByte[uhp_pkg::SB_BANK]) begin
                pipeBank[p] <= 1'b1;
            end
        end
    end

    // Freeze: hardware set wins over a software clear
    always_ff @(posedge clock) begin
        for (int p = 0; p < NP; p++) begin
            if (rst || usbReset) begin
                pipeFreeze[p] <= uhp_pkg::STAT_BIT_RST;
            end else if ((evHit[p] && (evt.kind == uhp_pkg::UHP_EV_STALL
                                       || evt.kind == uhp_pkg::UHP_EV_PIPE_ERROR_FLAG))
                         || penRise[p]) begin
                pipeFreeze[p] <= 1'b1;
            end else if (stClrW[p] && wByte[uhp_pkg::SB_FREEZE]) begin
                pipeFreeze[p] <= 1'b0;
            end else if (stSetW[p] && wByte[uhp_pkg::SB_FREEZE]) begin
                pipeFreeze[p] <= 1'b1;
            end
        end
    end

    // Bank ready bits, software owned
    always_ff @(posedge clock) begin
        for (int p = 0; p < NP; p++) begin
            if (rst || usbReset) begin
                bk0rdy_q[p] <= uhp_pkg::STAT_BIT_RST;
                bk1rdy_q[p] <= uhp_pkg::STAT_BIT_RST;
            end else begin
                if (stClrW[p] && wByte[uhp_pkg::SB_BK0RDY]) begin
                    bk0rdy_q[p] <= 1'b0;
                end else if (stSetW[p] && wByte[uhp_pkg::SB_BK0RDY]) begin
                    bk0rdy_q[p] <= 1'b1;
                end
                if (stClrW[p] && wByte[uhp_pkg::SB_BK1RDY]) begin
                    bk1rdy_q[p] <= 1'b0;
                end else if (stSetW[p] && wByte[uhp_pkg::SB_BK1RDY]) begin
                    bk1rdy_q[p] <= 1'b1;
                end
            end
        end
    end

    // Interrupt flags: a new event in the clearing cycle survives
    always_ff @(posedge clock) begin
        for (int p = 0; p < NP; p++) begin
            if (rst || usbReset) begin
                flags_q[p] <= uhp_pkg::FLAGS_RST;
            end else begin
                flags_q[p] <= (flags_q[p] & ~(flgW[p] ? wByte[5:0] : 6'h00))
                              | (evHit[p] ? eventFlags(evt, dbl_q[p], pipeBank[p]) : 6'h00);
            end
        end
    end

    // Interrupt enables, one state behind both set and clear registers
    always_ff @(posedge clock) begin
        for (int p = 0; p < NP; p++) begin
            if (rst || usbReset || !pen_q[p]) begin
                ien_q[p] <= uhp_pkg::IEN_RST;
            end else if (ienClrW[p]) begin
                ien_q[p] <= ien_q[p] & ~wByte[5:0];
            end else if (ienSetW[p]) begin
                ien_q[p] <= ien_q[p] | wByte[5:0];
            end
        end
    end

    // Any enabled, set flag across all pipes
    always_comb begin
        irqAny = 1'b0;
        for (int p = 0; p < NP; p++) begin
            irqAny = irqAny | (|(flags_q[p] & ien_q[p]));
        end
    end

    // Combined interrupt request, registered so the pin never glitches
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irqAny;
        end
    end

    // Read decode; unmapped indices read zero
    always_comb begin
        rdByte = 8'h00;
        if (idx == uhp_pkg::IDX_PIPE_EN) begin
            rdByte = pen_q;
        end else if (idx == uhp_pkg::IDX_DBL_BANK) begin
            rdByte = dbl_q;
        end else if (idx == uhp_pkg::IDX_IRQ_PEND) begin
            for (int p = 0; p < NP; p++) begin
                rdByte[p] = |(flags_q[p] & ien_q[p]);
            end
        end else begin
            for (int p = 0; p < NP; p++) begin
                if (pipeHit(idx, uhp_pkg::IDX_STATUS, p)) begin
                    rdByte = {bk1rdy_q[p], bk0rdy_q[p], 1'b0, pipeFreeze[p],
                              1'b0, pipeBank[p], 1'b0, pipeToggle[p]};
                end else if (pipeHit(idx, uhp_pkg::IDX_FLAGS, p)) begin
                    rdByte = {2'b00, flags_q[p]};
                end else if (pipeHit(idx, uhp_pkg::IDX_IEN_CLR, p)
                             || pipeHit(idx, uhp_pkg::IDX_IEN_SET, p)) begin
                    rdByte = {2'b00, ien_q[p]};
                end
            end
        end
    end

    // Bus answer: ack one cycle after the request, dropped after one cycle
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            ack_q  <= wbReq.cyc && wbReq.stb && !ack_q;
            rdat_q <= {24'h00_0000, rdByte};
        end
    end

    assign wbRsp.ack = ack_q;
    assign wbRsp.dat = rdat_q;
    assign irq       = irq_q;

endmodule

//--- uhp_pipe_irq_props.sv
// Purpose: Port-level checker of the pipe flag block.
// Assumes: One clock, synchronous reset.
// Notes:   Bound to every instance of the block.
module uhp_pipe_irq_props (
    // Clock and reset
    input wire logic                 clock,
    input wire logic                 rst,
    // Bus and events
    input wire uhp_pkg::uhp_wb_req_s wbReq,
    input wire uhp_pkg::uhp_wb_rsp_s wbRsp,
    input wire uhp_pkg::uhp_evt_s    evt,
    input wire logic                 usbReset,
    // Pipe state and interrupt
    input wire logic [7:0]           pipeToggle,
    input wire logic [7:0]           pipeBank,
    input wire logic [7:0]           pipeFreeze,
    input wire logic                 irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    wire logic req  = wbReq.cyc && wbReq.stb && !wbRsp.ack;
    wire logic done = evt.valid && evt.kind == uhp_pkg::UHP_EV_DONE && !usbReset;
    wire logic stp  = evt.token == uhp_pkg::UHP_TOK_SETUP;
    ack_one_cycle_a: assert property (req |=> wbRsp.ack)
        else $error("ack late");
    ack_pulse_a: assert property (wbRsp.ack |=> !wbRsp.ack)
        else $error("ack too long");
    reserved_zero_a: assert property (wbRsp.ack && !wbReq.we &&
        wbReq.adr[6:2] inside {5'h07, 5'h08, 5'h09} |-> wbRsp.dat[7:6] == 2'b00)
        else $error("reserved bits set");
    toggle_invert_a: assert property (done && !stp |=>
        pipeToggle[$past(evt.pipe)] != $past(pipeToggle[evt.pipe]))
        else $error("toggle kept");
    setup_toggle_a: assert property (done && stp |=> pipeToggle[$past(evt.pipe)])
        else $error("setup toggle wrong");
    stall_freeze_a: assert property (evt.valid && evt.kind == uhp_pkg::UHP_EV_STALL
        && !usbReset |=> pipeFreeze[$past(evt.pipe)])
        else $error("no freeze");
    ureset_state_a: assert property (usbReset && !evt.valid && !wbRsp.ack |=>
        pipeToggle == 8'h00 && pipeBank == 8'h00 && pipeFreeze == 8'h00)
        else $error("state kept");
    ureset_irq_a: assert property (usbReset |=> ##1 !irq)
        else $error("irq after usb reset");
    irq_cause_a: assert property ($rose(irq) |-> $past(evt.valid, 2) ||
        $past(wbRsp.ack, 2))
        else $error("irq without cause");
    cover property (req ##1 wbRsp.ack);
    cover property ($rose(irq));
    cover property (done && stp);
endmodule
bind uhp_pipe_irq uhp_pipe_irq_props chk (.clock(clock), .rst(rst), .wbReq(wbReq),
    .wbRsp(wbRsp), .evt(evt), .usbReset(usbReset), .pipeToggle(pipeToggle),
    .pipeBank(pipeBank), .pipeFreeze(pipeFreeze), .irq(irq));

//--- uhp_pkg.sv
// Purpose: Shared constants, types and register map of the host pipe flag block.
// Assumes: 32-bit classic Wishbone, register index = byte address / 4.
// Notes:   Every offset below is a register index; byte address is four times it.
// Functional notes
// - Each pipe keeps a toggle bit: 0 means DATA0 next, 1 means DATA1 next.
// - Hardware inverts the toggle after each completed IN or OUT data transaction.
// - Toggle follows the token: SETUP forces DATA1 next, IN and OUT invert it.
// - Status-clear write of one zeroes the toggle; status-set write of one sets it.
// - A STALL handshake sets flag bit 5.
// - Flags clear only by writing one; writing zero leaves them unchanged.
// - Setup-sent flag at bit 4 requests an interrupt only while enabled.
// - A detected pipe error sets flag bit 3.
// - A failed transfer sets flag bit 2.
// - Completion on a double-bank pipe with current bank 1 sets flag bit 1.
// - Completion on single-bank, or double-bank at bank 0, sets flag bit 0.
// - Bits 7:6 of flag and enable registers read zero; software writes zeros.
// - Enable-clear write of one disables a source; state reads back in both.
// - Enable-set write of one enables a source; state is shared by both.
// - Enables clear on USB reset and while the pipe enable is zero.
// - A source requests an interrupt while its flag and enable are both one.
// - Flag registers repeat per pipe at base plus stride times pipe number.
// - A received STALL sets the pipe freeze bit, stopping further requests.
// - Current bank selects the bank of the next packet: 0 bank 0, 1 bank 1.
package uhp_pkg;

    localparam int          PIPE_COUNT    = 8;
    localparam int          ADR_W         = 12;
    localparam int          IDX_W         = 10;
    localparam int          FLAG_W        = 6;

    // Register indices
    localparam logic [9:0]  IDX_PIPE_EN   = 10'h000;
    localparam logic [9:0]  IDX_DBL_BANK  = 10'h001;
    localparam logic [9:0]  IDX_IRQ_PEND  = 10'h002;
    localparam logic [9:0]  IDX_STAT_CLR  = 10'h104;
    localparam logic [9:0]  IDX_STAT_SET  = 10'h105;
    localparam logic [9:0]  IDX_STATUS    = 10'h106;
    localparam logic [9:0]  IDX_FLAGS     = 10'h107;
    localparam logic [9:0]  IDX_IEN_CLR   = 10'h108;
    localparam logic [9:0]  IDX_IEN_SET   = 10'h109;
    localparam logic [9:0]  PIPE_STRIDE   = 10'h020;

    // Flag and enable bit positions
    localparam int          FB_DONE0      = 0;
    localparam int          FB_DONE1      = 1;
    localparam int          FB_TRANSFER_FAIL_FLAG     = 2;
    localparam int          FB_PIPE_ERROR_FLAG       = 3;
    localparam int          FB_SETUP      = 4;
    localparam int          FB_STALL      = 5;

    // Status bit positions
    localparam int          SB_TOGGLE     = 0;
    localparam int          SB_BANK       = 2;
    localparam int          SB_FREEZE     = 4;
    localparam int          SB_BK0RDY     = 6;
    localparam int          SB_BK1RDY     = 7;

    // Reset values
    localparam logic [5:0]  FLAGS_RST     = 6'h00;
    localparam logic [5:0]  IEN_RST       = 6'h00;
    localparam logic [7:0]  CTRL_RST      = 8'h00;
    localparam logic        STAT_BIT_RST  = 1'b0;

    typedef enum logic [1:0] {
        UHP_EV_DONE   = 2'b00,
        UHP_EV_STALL  = 2'b01,
        UHP_EV_PIPE_ERROR_FLAG   = 2'b10,
        UHP_EV_TRANSFER_FAIL_FLAG = 2'b11
    } uhp_evt_e;

    typedef enum logic [1:0] {
        UHP_TOK_OUT   = 2'b00,
        UHP_TOK_IN    = 2'b01,
        UHP_TOK_SETUP = 2'b10
    } uhp_tok_e;

    typedef struct packed {
        logic        valid;
        logic [2:0]  pipe;
        uhp_evt_e    kind;
        uhp_tok_e    token;
    } uhp_evt_s;

    typedef struct packed {
        logic             cyc;
        logic             stb;
        logic             we;
        logic [3:0]       sel;
        logic [ADR_W-1:0] adr;
        logic [31:0]      dat;
    } uhp_wb_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } uhp_wb_rsp_s;

endpackage

//--- uhp_usb_dev.sv
// Purpose: Attached devices, seen as the events their answers cause.
// Assumes: Bench holds cmd valid for one cycle.
// Notes:   lag picks an answer delay of one to four cycles; idle fields churn.
module uhp_usb_dev (
    // Clock
    input  wire logic              clock,
    // Bench command
    input  wire uhp_pkg::uhp_evt_s cmd,
    input  wire logic [1:0]        lag,
    // Event toward the block
    output uhp_pkg::uhp_evt_s      evt
);
    timeunit 1ns;
    timeprecision 1ps;
    uhp_pkg::uhp_evt_s st[4];
    logic [6:0]        jk = 7'h00;
    always @(posedge clock) begin
        st[0] <= cmd;
        st[1] <= st[0];
        st[2] <= st[1];
        st[3] <= st[2];
        jk    <= jk + 7'h35;
    end
    // Idle fields carry a running count, not the last event
    assign evt = st[lag].valid ? st[lag] : uhp_pkg::uhp_evt_s'({1'b0, jk});
endmodule
